// [host_mcu_model.sv]
// host controller on the far side of the power switch pin
// assumes ground-switched supply and a push-pull reset line
module host_mcu_model
   import pwrsw_pkg::*;
(
   // clock
   input  wire logic          mclk,
   // pins from the block
   input  wire pin_drive_type sw_pin,
   input  wire pin_drive_type rst_n,
   // host side
   output logic               ext_irq,
   output logic               powered,
   output logic               in_reset
);
   logic last_r = 1'b0;
   // ground path conducts only while the pin pulls low
   assign powered  = sw_pin.oe && !sw_pin.level;
   // no pull-up on the host: only a driven low resets it
   assign in_reset = rst_n.oe && !rst_n.level;
   // unpowered host floats its line; toggle so no value sticks
   assign ext_irq  = powered ? 1'b1 : ~last_r;
   always @(posedge mclk) last_r <= ext_irq;
endmodule : host_mcu_model

// [pwrsw_pkg.sv]
// types shared by the power switch block
// assumes the constants header pwrsw_regs.svh
package pwrsw_pkg;
   // sleep state as reported by the sleep state machine
   typedef enum logic [1:0]
   {
      ST_RUN   = 2'b00,
      ST_SWAIT = 2'b01,
      ST_SLEEP = 2'b10
   } sleep_state_type;

   // one open-drain/push-pull pin: output level and enable
   typedef struct packed
   {
      logic level;
      logic oe;
   } pin_drive_type;
endpackage : pwrsw_pkg

// [pwrsw_regs.svh]
// register offsets, field positions and reset values for the power switch
// block; assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef PWRSW_REGS_SVH
`define PWRSW_REGS_SVH

// byte addresses (index times four)
`define ADDR_CONTROL1   6'h10
`define ADDR_CONTROL2   6'h14
`define ADDR_SLEEPCTRL  6'h18
`define ADDR_OUTCTRL    6'h1c
`define ADDR_OSCSTAT    6'h20
`define ADDR_STATUS     6'h24

// control1 fields
`define BIT_STATIC_LEVEL 5
`define BIT_LOW_RES_SW   1
// control2 field
`define SEL_LSB          2
`define SEL_MSB          4
`define SEL_RESET        3'h7
`define SEL_SLEEP        3'h6
// sleep control field
`define BIT_SLEEP_RST_EN 6
// output control fields
`define BIT_EXT_DIS      7
`define BIT_WDOG_DIS     6
`define BIT_RST_OUT_EN   4
`define BIT_CLK_OUT_EN   3
`define BIT_TIMER_OUT_EN 2
`define BIT_FREQ_OUT_EN  0
`define OUTCTRL_RESET    8'h1d
// osc status field
`define BIT_LEVEL_LOCK   5

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [sleep_power_switch_output.sv]
// power switch pin, sleep reset and leakage control of the rtc
// assumes the sleep state machine sits elsewhere on MCLK and reports its
// state; pins from the outside pass a two-flop synchroniser here
//
// Contract
// R1 - after reset the selector is 7 and the static level bit is 0.
// R2 - the static level bit may become 1 only while the lock bit is clear.
// R3 - in power switch use software writes only selector codes 6 or 7.
// R4 - code 7 picks the static bit, code 6 picks the sleep function.
// R5 - with sleep selected the pin pulls low while awake, opens in sleep.
// R6 - with sleep reset enabled, reset goes low in sleep, released on wake.
// R7 - host disables its reset pull-up; reset output used push-pull.
// R8 - software sets input disables for inputs from powered-down parts.
// R9 - software clears output enables for outputs to powered-down parts.
// R10 - timer interrupt output enable exists only on two-wire variants.
// R11 - the supply-switched case handles sleep like the ground case.
// R12 - code 6 with low-resistance bit is open drain, else high-true sleep.
// R13 - sleep removes the power switch signal; wake restores it.
// R14 - a locked set of the static bit is ignored; clears always work.
`include "pwrsw_regs.svh"

module sleep_power_switch_output
   import pwrsw_pkg::*;
#(
   parameter bit TWO_WIRE_VARIANT = 1'b1
)
(
   // clock and reset
   input  wire logic            MCLK,
   input  wire logic            RESET_N,
   // sleep state machine
   input  wire sleep_state_type SLEEP_STATE,
   // raw pins and internal sources
   input  wire logic            EXT_IRQ_IN,
   input  wire logic            WDOG_IN,
   input  wire logic            FREQ_SRC,
   input  wire logic            TIMER_SRC,
   input  wire logic            CLK_SRC,
   input  wire logic            RESET_SRC_N,
   // filtered inputs to the core
   output logic                 EXT_IRQ_SYNC,
   output logic                 WDOG_SYNC,
   // pins
   output pin_drive_type        POWER_SWITCH_PIN,
   output pin_drive_type        SYSTEM_RESET_OUT_N,
   output pin_drive_type        FREQ_IRQ_PIN,
   output pin_drive_type        TIMER_IRQ_PIN,
   output pin_drive_type        CLOCK_IRQ3_PIN,
   // axi4-lite slave
   input  wire logic [5:0]      S_AXI_AWADDR,
   input  wire logic            S_AXI_AWVALID,
   output logic                 S_AXI_AWREADY,
   input  wire logic [31:0]     S_AXI_WDATA,
   input  wire logic [3:0]      S_AXI_WSTRB,
   input  wire logic            S_AXI_WVALID,
   output logic                 S_AXI_WREADY,
   output logic [1:0]           S_AXI_BRESP,
   output logic                 S_AXI_BVALID,
   input  wire logic            S_AXI_BREADY,
   input  wire logic [5:0]      S_AXI_ARADDR,
   input  wire logic            S_AXI_ARVALID,
   output logic                 S_AXI_ARREADY,
   output logic [31:0]          S_AXI_RDATA,
   output logic [1:0]           S_AXI_RRESP,
   output logic                 S_AXI_RVALID,
   input  wire logic            S_AXI_RREADY
);

   // control registers
   logic [7:0]  control1_r;
   logic [7:0]  control2_r;
   logic [7:0]  sleepctrl_r;
   logic [7:0]  outctrl_r;
   logic [7:0]  oscstat_r;
   logic [7:0]  control1_nxt;

   // write and read channel capture
   logic        aw_held_r;
   logic [5:0]  aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic        w_lane0_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // synchronisers
   logic [1:0]  ext_sync_r;
   logic [1:0]  wdog_sync_r;

   // pin flops
   pin_drive_type sw_pin_r;
   pin_drive_type rst_r;
   pin_drive_type freq_r;
   pin_drive_type timer_r;
   pin_drive_type clk_r;

   // ---------------- bus decode ----------------
   // one write and one read at a time; address and data in any order
   wire do_write   = aw_held_r && w_held_r && !bvalid_r;
   wire wr_c1      = do_write && (aw_addr_r == `ADDR_CONTROL1);
   wire wr_c2      = do_write && (aw_addr_r == `ADDR_CONTROL2);
   wire wr_sc      = do_write && (aw_addr_r == `ADDR_SLEEPCTRL);
   wire wr_oc      = do_write && (aw_addr_r == `ADDR_OUTCTRL);
   wire wr_os      = do_write && (aw_addr_r == `ADDR_OSCSTAT);
   wire wr_ro      = do_write && (aw_addr_r == `ADDR_STATUS);
   wire wr_hit     = wr_c1 || wr_c2 || wr_sc || wr_oc || wr_os || wr_ro;
   wire [7:0] wbyte = w_data_r[7:0];
   wire rd_take    = S_AXI_ARVALID && !rvalid_r;

   assign S_AXI_AWREADY = !aw_held_r;
   assign S_AXI_WREADY  = !w_held_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;

   // static level may only rise while unlocked; clearing always lands
   wire lock       = oscstat_r[`BIT_LEVEL_LOCK];
   wire lvl_old    = control1_r[`BIT_STATIC_LEVEL];
   wire lvl_req    = wbyte[`BIT_STATIC_LEVEL];
   wire lvl_new    = lvl_req && (lvl_old || !lock);   // [R2] [R14]

   always_comb
   begin
      control1_nxt = control1_r;
      if (wr_c1 && w_lane0_r)
      begin
         control1_nxt = wbyte;
         control1_nxt[`BIT_STATIC_LEVEL] = lvl_new;
      end
   end

   // status word: sleep state and the current pin level
   wire [31:0] status_word = {26'h0, rst_r.level, sw_pin_r.oe, sw_pin_r.level,
                              1'b0, SLEEP_STATE};

   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb
   begin
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         `ADDR_CONTROL1:  rd_mux = {24'h0, control1_r};
         `ADDR_CONTROL2:  rd_mux = {24'h0, control2_r};
         `ADDR_SLEEPCTRL: rd_mux = {24'h0, sleepctrl_r};
         `ADDR_OUTCTRL:   rd_mux = {24'h0, outctrl_r};
         `ADDR_OSCSTAT:   rd_mux = {24'h0, oscstat_r};
         `ADDR_STATUS:    rd_mux = status_word;
         default:
         begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ---------------- bus handshake ----------------
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 6'h0;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h0;
         w_lane0_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_held_r)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_held_r)
         begin
            w_held_r  <= 1'b1;
            w_data_r  <= S_AXI_WDATA;
            w_lane0_r <= S_AXI_WSTRB[0];
         end
         if (do_write)
         begin
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
         end
         else if (bvalid_r && S_AXI_BREADY)
            bvalid_r <= 1'b0;
      end
   end

   // read answers one cycle after the address is taken
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= `RESP_OKAY;
      end
      else if (rd_take)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
         rvalid_r <= 1'b0;
   end

   // ---------------- register file ----------------
   // selector resets to static level, which resets low: power on
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         control1_r  <= 8'h0;                          // [R1]
         control2_r  <= {3'h0, `SEL_RESET, 2'h0};      // [R1]
         sleepctrl_r <= 8'h0;
         outctrl_r   <= `OUTCTRL_RESET;
         oscstat_r   <= 8'h0;
      end
      else
      begin
         control1_r <= control1_nxt;
         if (wr_c2 && w_lane0_r)
            control2_r <= wbyte;
         if (wr_sc && w_lane0_r)
            sleepctrl_r <= wbyte;
         if (wr_oc && w_lane0_r)
            outctrl_r <= wbyte;
         if (wr_os && w_lane0_r)
            oscstat_r <= wbyte;
      end
   end

   // ---------------- pin logic ----------------
   wire [2:0] sel      = control2_r[`SEL_MSB:`SEL_LSB];
   wire asleep         = (SLEEP_STATE == ST_SLEEP);
   wire low_res        = control1_r[`BIT_LOW_RES_SW];
   wire static_lvl     = control1_r[`BIT_STATIC_LEVEL];
   wire sleep_reset_enable = sleepctrl_r[`BIT_SLEEP_RST_EN];
   wire power_switch_signal = !asleep;                 // [R13]

   // only codes 6 and 7 are glitch safe; others park the pin low [R3] [R4]
   pin_drive_type sw_pin_nxt;
   always_comb
   begin
      sw_pin_nxt = '{level: 1'b0, oe: 1'b1};
      case (sel)
         `SEL_RESET:
            sw_pin_nxt = '{level: static_lvl, oe: 1'b1};  // [R1] [R4]
         `SEL_SLEEP:
            if (low_res)                                  // [R12]
               // ground pulled while powered, open in sleep [R5] [R11]
               sw_pin_nxt = '{level: 1'b0, oe: power_switch_signal};
            else
               sw_pin_nxt = '{level: asleep, oe: 1'b1};   // [R12]
         default:
            sw_pin_nxt = '{level: 1'b0, oe: 1'b1};
      endcase
   end

   // reset: low in sleep when enabled, released on wake; push-pull [R7]
   wire rst_low   = (sleep_reset_enable && asleep) || !RESET_SRC_N; // [R6]
   wire rst_en    = outctrl_r[`BIT_RST_OUT_EN];               // [R9]
   wire timer_en  = TWO_WIRE_VARIANT &&
                    outctrl_r[`BIT_TIMER_OUT_EN];             // [R10]

   // pins registered so that no decode glitch reaches them
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         sw_pin_r <= '{level: 1'b0, oe: 1'b1};
         rst_r   <= '{level: 1'b0, oe: 1'b1};
         freq_r  <= '{level: 1'b0, oe: 1'b1};
         timer_r <= '{level: 1'b0, oe: 1'b0};
         clk_r   <= '{level: 1'b0, oe: 1'b0};
      end
      else
      begin
         sw_pin_r <= sw_pin_nxt;
         rst_r   <= '{level: !rst_low, oe: rst_en};
         freq_r  <= '{level: FREQ_SRC,
                      oe: outctrl_r[`BIT_FREQ_OUT_EN]};    // [R9]
         timer_r <= '{level: TIMER_SRC, oe: timer_en};
         clk_r   <= '{level: CLK_SRC,
                      oe: outctrl_r[`BIT_CLK_OUT_EN]};     // [R9]
      end
   end

   assign POWER_SWITCH_PIN   = sw_pin_r;
   assign SYSTEM_RESET_OUT_N = rst_r;
   assign FREQ_IRQ_PIN       = freq_r;
   assign TIMER_IRQ_PIN      = timer_r;
   assign CLOCK_IRQ3_PIN     = clk_r;

   // ---------------- input synchronisers ----------------
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         ext_sync_r  <= 2'b00;
         wdog_sync_r <= 2'b00;
      end
      else
      begin
         ext_sync_r  <= {ext_sync_r[0], EXT_IRQ_IN};
         wdog_sync_r <= {wdog_sync_r[0], WDOG_IN};
      end
   end

   // disabled inputs read zero while asleep, so floating pins are ignored
   assign EXT_IRQ_SYNC = ext_sync_r[1] &&
                         !(asleep && outctrl_r[`BIT_EXT_DIS]);   // [R8]
   assign WDOG_SYNC    = wdog_sync_r[1] &&
                         !(asleep && outctrl_r[`BIT_WDOG_DIS]);  // [R8]

endmodule : sleep_power_switch_output

// [sleep_power_switch_output_properties.sv]
// port checker for the power switch block
// assumes the top module's ports and one clock domain
module sleep_power_switch_output_checker
   import pwrsw_pkg::*;
#(
   parameter bit TWO_WIRE_VARIANT = 1'b1
)
(
   // clock and reset
   input wire logic            MCLK,
   input wire logic            RESET_N,
   // state and sources
   input wire sleep_state_type SLEEP_STATE,
   input wire logic            RESET_SRC_N,
   // pins
   input wire pin_drive_type   POWER_SWITCH_PIN,
   input wire pin_drive_type   SYSTEM_RESET_OUT_N,
   input wire pin_drive_type   TIMER_IRQ_PIN
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   // wake: asleep, then awake with no other reset source
   sequence wake_seq;
      SLEEP_STATE == ST_SLEEP ##1 SLEEP_STATE == ST_RUN && RESET_SRC_N;
   endsequence
   chk_psw_reset: assert property (
      $rose(RESET_N) |-> POWER_SWITCH_PIN == 2'b01)
      else $error("power switch not conducting after reset");
   chk_open_low: assert property (
      !POWER_SWITCH_PIN.oe |-> !POWER_SWITCH_PIN.level)
      else $error("released pin shows a high level");
   chk_open_cause: assert property (
      !POWER_SWITCH_PIN.oe |-> $past(SLEEP_STATE) == ST_SLEEP)
      else $error("pin released outside sleep");
   chk_awake_drive: assert property (
      SLEEP_STATE != ST_SLEEP |=> POWER_SWITCH_PIN.oe)
      else $error("pin not driven while awake");
   chk_rst_cause: assert property (
      $past(RESET_N) && !SYSTEM_RESET_OUT_N.level |->
      $past(SLEEP_STATE) == ST_SLEEP || !$past(RESET_SRC_N))
      else $error("reset low without a cause");
   chk_rst_wake: assert property (
      wake_seq |=> SYSTEM_RESET_OUT_N.level)
      else $error("reset held after wake");
   chk_rst_other: assert property (
      !RESET_SRC_N |=> !SYSTEM_RESET_OUT_N.level)
      else $error("other reset source ignored");
   chk_timer_off: assert property (
      !TWO_WIRE_VARIANT |-> !TIMER_IRQ_PIN.oe)
      else $error("timer pin enabled on wrong variant");
endmodule : sleep_power_switch_output_checker

// [tb_sleep_power_switch_output.sv]
// bench for the power switch block over axi4-lite
// assumes the checker and host model are compiled first
`include "pwrsw_regs.svh"
module tb_sleep_power_switch_output
   import pwrsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic            mclk = 0, rst_n = 0, rsrc_n = 1;
   sleep_state_type sstate = ST_RUN;
   logic [5:0]      awaddr = '0, araddr = '0;
   logic [31:0]     wdata = '0, rdata, rd;
   logic            awvalid = 0, wvalid = 0, bready = 0;
   logic            arvalid = 0, rready = 0;
   logic            awready, wready, bvalid, arready, rvalid;
   logic            ext, ext_sync, powered, in_rst;
   logic            src = 0, wsync;
   logic [1:0]      bresp, rresp, rr;
   pin_drive_type   sw_pin, rpin, fpin, tpin, cpin;
   int              bad_count = 0, checks_done = 0;
   // 10 mhz clock
   always #50 mclk = ~mclk;
   sleep_power_switch_output sleep_power_switch_output_i (
      .MCLK(mclk), .RESET_N(rst_n), .SLEEP_STATE(sstate),
      .EXT_IRQ_IN(ext), .WDOG_IN(ext), .FREQ_SRC(src),
      .TIMER_SRC(src), .CLK_SRC(src), .RESET_SRC_N(rsrc_n),
      .EXT_IRQ_SYNC(ext_sync), .WDOG_SYNC(wsync),
      .POWER_SWITCH_PIN(sw_pin), .SYSTEM_RESET_OUT_N(rpin),
      .FREQ_IRQ_PIN(fpin), .TIMER_IRQ_PIN(tpin), .CLOCK_IRQ3_PIN(cpin),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   host_mcu_model host_mcu_model_i (.mclk(mclk), .sw_pin(sw_pin),
      .rst_n(rpin), .ext_irq(ext), .powered(powered),
      .in_reset(in_rst));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // write: address and data offered together, each released when taken;
   // a local flag ends the wait, since the valids only update after the edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            rr = bresp;
            done = 1'b1;
         end
      end
   endtask : wr
   task automatic rdr(input logic [5:0] a);
      logic done = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            rd = rdata;
            rr = rresp;
            done = 1'b1;
         end
      end
   endtask : rdr
   // pins lag the state by one edge; look once settled
   task automatic go(input sleep_state_type s);
      @(posedge mclk);
      sstate <= s;
      repeat (3) @(negedge mclk);
   endtask : go
   task automatic t_reset;
      rdr(`ADDR_CONTROL2);
      chk(rd, 32'h1c);
      rdr(`ADDR_CONTROL1);
      chk(rd, 32'h0);
      @(negedge mclk);
      chk(32'(sw_pin), 32'h1);
      rdr(6'h3c);
      chk(32'(rr), 32'(`RESP_SLVERR));
      wr(6'h3c, 32'h0);
      chk(32'(rr), 32'(`RESP_SLVERR));
   endtask : t_reset
   task automatic t_lock;
      wr(`ADDR_OSCSTAT, 32'h20);
      chk(32'(rr), 32'(`RESP_OKAY));
      wr(`ADDR_CONTROL1, 32'h20);
      rdr(`ADDR_CONTROL1);
      chk(rd, 32'h0);
      wr(`ADDR_OSCSTAT, 32'h0);
      wr(`ADDR_CONTROL1, 32'h20);
      rdr(`ADDR_CONTROL1);
      chk(rd, 32'h20);
      go(ST_RUN);
      chk(32'(sw_pin), 32'h3);
      chk(32'(powered), 32'h0);
      wr(`ADDR_OSCSTAT, 32'h20);
      wr(`ADDR_CONTROL1, 32'h0);
      rdr(`ADDR_CONTROL1);
      chk(rd, 32'h0);
      wr(`ADDR_OSCSTAT, 32'h0);
   endtask : t_lock
   task automatic t_sleep;
      wr(`ADDR_CONTROL1, 32'h02);
      wr(`ADDR_CONTROL2, 32'h18);
      go(ST_SWAIT);
      chk(32'(sw_pin), 32'h1);
      go(ST_SLEEP);
      chk(32'(sw_pin), 32'h0);
      chk(32'(powered), 32'h0);
      go(ST_RUN);
      chk(32'(sw_pin), 32'h1);
      wr(`ADDR_CONTROL1, 32'h0);
      go(ST_SLEEP);
      chk(32'(sw_pin), 32'h3);
      go(ST_RUN);
      chk(32'(sw_pin), 32'h1);
      wr(`ADDR_CONTROL2, 32'h1c);
   endtask : t_sleep
   task automatic t_rst;
      wr(`ADDR_OUTCTRL, 32'hdd);
      wr(`ADDR_SLEEPCTRL, 32'h40);
      go(ST_SLEEP);
      chk(32'(rpin), 32'h1);
      chk(32'(in_rst), 32'h1);
      chk(32'(ext_sync), 32'h0);
      chk(32'(wsync), 32'h0);
      go(ST_RUN);
      chk(32'(rpin), 32'h3);
      chk(32'(ext_sync), 32'h1);
      chk(32'(wsync), 32'h1);
      @(posedge mclk);
      rsrc_n <= 1'b0;
      repeat (2) @(negedge mclk);
      chk(32'(rpin.level), 32'h0);
      @(posedge mclk);
      rsrc_n <= 1'b1;
   endtask : t_rst
   // output enables gate the source pins; the timer pin exists here
   task automatic t_outs;
      @(posedge mclk);
      src <= 1'b1;
      repeat (2) @(negedge mclk);
      chk(32'({fpin, tpin, cpin}), 32'h3f);
      wr(`ADDR_OUTCTRL, 32'h0);
      @(negedge mclk);
      chk(32'({fpin, tpin, cpin, rpin}), 32'haa);
   endtask : t_outs
   task automatic stop_test;
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   // main sequence after a three-cycle reset
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_lock();
      t_sleep();
      t_rst();
      t_outs();
      stop_test();
   end
   // watchdog, well past the expected run
   initial
   begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : tb_sleep_power_switch_output
bind sleep_power_switch_output sleep_power_switch_output_checker
   #(.TWO_WIRE_VARIANT(TWO_WIRE_VARIANT)) chk_i (.MCLK(MCLK),
   .RESET_N(RESET_N), .SLEEP_STATE(SLEEP_STATE),
   .RESET_SRC_N(RESET_SRC_N), .POWER_SWITCH_PIN(POWER_SWITCH_PIN),
   .SYSTEM_RESET_OUT_N(SYSTEM_RESET_OUT_N),
   .TIMER_IRQ_PIN(TIMER_IRQ_PIN));
